// >>> design/nvsp_host.sv
// host controller driving a nonvolatile sram over its parallel pins
// assumes pins are synchronous to clk; the board resolves dq and the
// open-drain save line from the enables
`timescale 1ns/1ps
`include "nvsp_params.svh"

module nvsp_host import nvsp_pkg::*; #(
  parameter bit WIDE = 1'b1,
  parameter int TRC_CYC = nvsp_cyc(`NVSP_TRC_NS, `NVSP_CLK_NS),
  parameter int TWC_CYC = nvsp_cyc(`NVSP_TWC_NS, `NVSP_CLK_NS),
  parameter int TPHSB_CYC = nvsp_cyc(`NVSP_TPHSB_NS, `NVSP_CLK_NS),
  parameter int TDHSB_CYC = nvsp_cyc(`NVSP_TDHSB_NS, `NVSP_CLK_NS),
  parameter int TSS_CYC = nvsp_cyc(`NVSP_TSS_NS, `NVSP_CLK_NS),
  parameter int TRECALL_CYC = nvsp_cyc(`NVSP_TRECALL_NS, `NVSP_CLK_NS),
  parameter int TSTORE_CYC = nvsp_cyc(`NVSP_TSTORE_NS, `NVSP_CLK_NS),
  parameter int TBOOT_CYC = nvsp_cyc(`NVSP_TBOOT_NS, `NVSP_CLK_NS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // user side
  input wire nvsp_req_t req,
  output nvsp_rsp_t rsp,
  // memory pins
  output nvsp_pin_t pins,
  input wire logic [15:0] dq_i,
  input wire logic hw_save_line_n_i
);

  typedef enum logic [2:0] {
    S_BOOT, S_IDLE, S_ACC, S_SEQ, S_GAP, S_WAIT, S_HPULSE, S_HWAIT
  } nvsp_st_t;

  localparam nvsp_pin_t PIN_IDLE = '{
    ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, upper_byte_sel_n: 1'b1,
    lower_byte_sel_n: 1'b1, addr: 17'h00000, dq_o: 16'h0000,
    dq_oe: 2'h0, hw_save_line_n_o: 1'b0, hw_save_line_n_oe: 1'b0};

  logic rst_s1_r;
  logic rst_n_r;
  nvsp_st_t st_r, st_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [2:0] idx_r, idx_nxt;
  nvsp_op_t op_r, op_nxt;
  nvsp_pin_t pin_r, pin_nxt;
  nvsp_rsp_t rsp_r, rsp_nxt;
  logic [31:0] lo_cnt_r;

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  function automatic logic [16:0] seq_addr(input logic [2:0] i,
                                           input logic rec);
    case (i)
      3'h0: seq_addr = `NVSP_SEQ_A0;
      3'h1: seq_addr = `NVSP_SEQ_A1;
      3'h2: seq_addr = `NVSP_SEQ_A2;
      3'h3: seq_addr = `NVSP_SEQ_A3;
      3'h4: seq_addr = `NVSP_SEQ_A4;
      3'h5: seq_addr = rec ? `NVSP_SEQ_RECALL : `NVSP_SEQ_STORE;
      default: seq_addr = 17'h00000;
    endcase
  endfunction

  // pins for one sequence read: chip and output strobe low, write high
  function automatic nvsp_pin_t seq_pins(input logic [2:0] i,
                                         input logic rec);
    nvsp_pin_t p;
    p = PIN_IDLE;
    p.ce_n = 1'b0;
    p.oe_n = 1'b0;
    p.we_n = 1'b1;
    p.upper_byte_sel_n = ~WIDE;
    p.lower_byte_sel_n = ~WIDE;
    p.addr = seq_addr(i, rec);
    return p;
  endfunction

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 32'h00000001;
    idx_nxt = idx_r;
    op_nxt = op_r;
    pin_nxt = pin_r;
    rsp_nxt = rsp_r;
    rsp_nxt.done = 1'b0;
    case (st_r)
      S_BOOT: begin
        // wait out the power-up restore before any access
        if (cnt_r >= 32'(TBOOT_CYC - 1)) begin
          st_nxt = S_IDLE;
          rsp_nxt.ready = 1'b1;
        end
      end
      S_IDLE: begin
        cnt_nxt = 32'h00000000;
        if (req.valid && rsp_r.ready) begin
          rsp_nxt.ready = 1'b0;
          op_nxt = req.op;
          idx_nxt = 3'h0;
          pin_nxt = PIN_IDLE;
          case (req.op)
            NVSP_OP_READ, NVSP_OP_WRITE: begin
              // chip low; write strobe low for write, else output low
              pin_nxt.ce_n = 1'b0;
              pin_nxt.addr = WIDE ? {1'b0, req.addr[15:0]} : req.addr;
              pin_nxt.lower_byte_sel_n = WIDE ? ~req.be[0] : 1'b1;
              pin_nxt.upper_byte_sel_n = WIDE ? ~req.be[1] : 1'b1;
              if (req.op == NVSP_OP_WRITE) begin
                pin_nxt.we_n = 1'b0;
                pin_nxt.dq_o = WIDE ? req.wdata : {8'h00, req.wdata[7:0]};
                pin_nxt.dq_oe = WIDE ? req.be : 2'h1;
              end else begin
                pin_nxt.oe_n = 1'b0;
              end
              st_nxt = S_ACC;
            end
            NVSP_OP_STORE, NVSP_OP_RECALL: begin
              pin_nxt = seq_pins(3'h0, req.op == NVSP_OP_RECALL);
              st_nxt = S_SEQ;
            end
            NVSP_OP_HWSAVE: begin
              // pulled low only from idle, never during an access
              pin_nxt.hw_save_line_n_oe = 1'b1;
              st_nxt = S_HPULSE;
            end
            default: begin
              rsp_nxt.ready = 1'b1;
              rsp_nxt.done = 1'b1;
            end
          endcase
        end
      end
      S_ACC: begin
        if (cnt_r == 32'(((op_r == NVSP_OP_WRITE) ? TWC_CYC : TRC_CYC) - 1))
        begin
          if (op_r == NVSP_OP_READ) begin
            rsp_nxt.rdata = WIDE ? dq_i : {8'h00, dq_i[7:0]};
          end
          pin_nxt = PIN_IDLE;
          st_nxt = S_IDLE;
          rsp_nxt.ready = 1'b1;
          rsp_nxt.done = 1'b1;
        end
      end
      S_SEQ: begin
        // each read held for the initiation cycle time
        if (cnt_r == 32'(TRC_CYC - 1)) begin
          pin_nxt = PIN_IDLE;
          idx_nxt = idx_r + 3'h1;
          cnt_nxt = 32'h00000000;
          // sixth read data is never sampled
          st_nxt = (idx_r == `NVSP_IDX_LAST) ? S_WAIT : S_GAP;
        end
      end
      S_GAP: begin
        // chip strobe high one cycle so each read is a separate edge
        pin_nxt = seq_pins(idx_r, op_r == NVSP_OP_RECALL);
        cnt_nxt = 32'h00000000;
        st_nxt = S_SEQ;
      end
      S_WAIT: begin
        // no access until the command is processed and finished
        if (cnt_r == 32'(TSS_CYC + ((op_r == NVSP_OP_RECALL) ?
            TRECALL_CYC : TSTORE_CYC) - 1)) begin
          st_nxt = S_IDLE;
          rsp_nxt.ready = 1'b1;
          rsp_nxt.done = 1'b1;
        end
      end
      S_HPULSE: begin
        if (cnt_r == 32'(TPHSB_CYC - 1)) begin
          pin_nxt.hw_save_line_n_oe = 1'b0;
          cnt_nxt = 32'h00000000;
          st_nxt = S_HWAIT;
        end
      end
      S_HWAIT: begin
        // line high again: save done or skipped for lack of writes
        if (cnt_r >= 32'(TDHSB_CYC - 1) && hw_save_line_n_i) begin
          st_nxt = S_IDLE;
          rsp_nxt.ready = 1'b1;
          rsp_nxt.done = 1'b1;
        end
      end
      default: begin
        st_nxt = S_BOOT;
        cnt_nxt = 32'h00000000;
        pin_nxt = PIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= S_BOOT;
      cnt_r <= 32'h00000000;
      idx_r <= 3'h0;
      op_r <= NVSP_OP_READ;
      pin_r <= PIN_IDLE;
      rsp_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      op_r <= op_nxt;
      pin_r <= pin_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign pins = pin_r;
  assign rsp = rsp_r;

  // length of the current chip strobe low run, for checks only
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lo_cnt_r <= 32'h00000000;
    end else begin
      lo_cnt_r <= pin_r.ce_n ? 32'h00000000 : lo_cnt_r + 32'h00000001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_r);

  property p_seq_read_strobe;
    $fell(pin_r.ce_n) && (st_r == S_SEQ) |-> !pin_r.oe_n && pin_r.we_n;
  endproperty
  a_seq_read_strobe: assert property (p_seq_read_strobe)
    else $error("sequence access is not a read");

  property p_seq_order;
    $fell(pin_r.ce_n) && (st_r == S_SEQ) |->
      pin_r.addr == seq_addr(idx_r, op_r == NVSP_OP_RECALL);
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("sequence address out of order");

  property p_seq_we_high;
    (st_r == S_SEQ) && $past(st_r == S_IDLE) |->
      pin_r.we_n throughout (##[0:300] st_r == S_WAIT);
  endproperty
  a_seq_we_high: assert property (p_seq_we_high)
    else $error("write strobe low during sequence");

  property p_seq_read_len;
    $rose(pin_r.ce_n) && $past(pin_r.we_n) |->
      lo_cnt_r >= 32'(TRC_CYC);
  endproperty
  a_seq_read_len: assert property (p_seq_read_len)
    else $error("read shorter than cycle time");

  property p_save_line_idle;
    !pin_r.ce_n |-> !pin_r.hw_save_line_n_oe;
  endproperty
  a_save_line_idle: assert property (p_save_line_idle)
    else $error("save line pulled during access");

  property p_sixth_wait;
    $rose(st_r == S_WAIT) |-> $past(pin_r.addr, 2) ==
      seq_addr(`NVSP_IDX_LAST, op_r == NVSP_OP_RECALL) && !rsp_r.ready;
  endproperty
  a_sixth_wait: assert property (p_sixth_wait)
    else $error("wait entered without sixth read");

endmodule

// >>> design/nvsp_params.svh
// constants of the nonvolatile sram store/recall host port
// assumes a 4 ns system clock and the slowest speed grade by default
`ifndef NVSP_PARAMS_SVH
`define NVSP_PARAMS_SVH

// clock period
`define NVSP_CLK_NS 4
// read and initiation cycle, write cycle, least times
`define NVSP_TRC_NS 45
`define NVSP_TWC_NS 45
// hardware save pulse, least time
`define NVSP_TPHSB_NS 15
// save line return when nothing to save
`define NVSP_TDHSB_NS 25
// soft sequence processing, restore, save and power-up restore
`define NVSP_TSS_NS 100000
`define NVSP_TRECALL_NS 200000
`define NVSP_TSTORE_NS 8000000
`define NVSP_TBOOT_NS 20000000
// command sequence addresses
`define NVSP_SEQ_A0 17'h00001
`define NVSP_SEQ_A1 17'h00002
`define NVSP_SEQ_A2 17'h00003
`define NVSP_SEQ_A3 17'h00004
`define NVSP_SEQ_A4 17'h00005
`define NVSP_SEQ_STORE 17'h00006
`define NVSP_SEQ_RECALL 17'h00007
`define NVSP_IDX_LAST 3'h5

`endif

// >>> design/nvsp_pkg.sv
// types of the nonvolatile sram store/recall host port
// assumes nothing beyond the constants header
package nvsp_pkg;

  typedef enum logic [2:0] {
    NVSP_OP_READ,
    NVSP_OP_WRITE,
    NVSP_OP_STORE,
    NVSP_OP_RECALL,
    NVSP_OP_HWSAVE
  } nvsp_op_t;

  typedef struct packed {
    logic valid;
    nvsp_op_t op;
    logic [16:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
  } nvsp_req_t;

  typedef struct packed {
    logic ready;
    logic done;
    logic [15:0] rdata;
  } nvsp_rsp_t;

  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic upper_byte_sel_n;
    logic lower_byte_sel_n;
    logic [16:0] addr;
    logic [15:0] dq_o;
    logic [1:0] dq_oe;
    logic hw_save_line_n_o;
    logic hw_save_line_n_oe;
  } nvsp_pin_t;

  // least time in ns to whole clock cycles, rounded up
  function automatic int nvsp_cyc(input int ns, input int clk_ns);
    return (ns + clk_ns - 1) / clk_ns;
  endfunction

endpackage

// >>> verif/nvsp_dev_model.sv
// behavioural model of the nonvolatile sram on the far side of the host
// assumes pins change on clk; tallies protocol faults of the host in n_viol
`timescale 1ns/1ps
`include "nvsp_params.svh"

module nvsp_dev_model import nvsp_pkg::*; #(
  parameter int TSS_CYC = 10,
  parameter int TSTORE_CYC = 20,
  parameter int TRECALL_CYC = 10,
  parameter int TBOOT_CYC = 20
) (
  // clock and supply
  input wire logic clk,
  input wire logic resetn,
  // memory pins
  input wire nvsp_pin_t pins,
  output logic [15:0] dq,
  output logic save_line_n,
  // tallies
  output int n_store,
  output int n_recall,
  output int n_viol
);
  int idx, busy, rd_len, hs, boot;
  logic ce_q, latch, cmd;
  logic [15:0] last, mem [0:255], nv [0:255];
  wire [7:0] wa = pins.addr[7:0];
  wire [15:0] wd = {pins.dq_oe[1] ? pins.dq_o[15:8] : ~last[15:8],
    pins.dq_oe[0] ? pins.dq_o[7:0] : ~last[7:0]};

  // pull-up unless someone pulls low
  assign save_line_n = !(pins.hw_save_line_n_oe || hs > 0);

  always_comb begin
    dq = ~last;
    if (!pins.ce_n && pins.we_n && !pins.oe_n && busy == 0 && idx != 6) begin
      if (!pins.lower_byte_sel_n) dq[7:0] = mem[wa][7:0];
      if (!pins.upper_byte_sel_n) dq[15:8] = mem[wa][15:8];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {idx, busy, rd_len, hs, n_store, n_recall, n_viol} <= '0;
      boot <= TBOOT_CYC;
      {ce_q, latch, cmd, last} <= {3'h4, 16'h0};
    end else begin
      last <= dq;
      ce_q <= pins.ce_n;
      if (boot > 0) boot <= boot - 1;
      if (busy > 0) busy <= busy - 1;
      if (!pins.ce_n && (busy > 0 || boot > 0 || !save_line_n))
        n_viol <= n_viol + 1;
      if (!pins.ce_n && !pins.we_n && busy == 0) begin
        if (!pins.lower_byte_sel_n) mem[wa][7:0] <= wd[7:0];
        if (!pins.upper_byte_sel_n) mem[wa][15:8] <= wd[15:8];
        latch <= 1'b1;
        idx <= 0;
      end
      if (ce_q && !pins.ce_n && pins.we_n && !pins.oe_n) begin
        rd_len <= 1;
        cmd <= pins.addr == `NVSP_SEQ_STORE;
        if (idx < 5 && pins.addr == `NVSP_SEQ_A0 + 17'(idx))
          idx <= idx + 1;
        else if (idx == 5 && (pins.addr == `NVSP_SEQ_STORE ||
          pins.addr == `NVSP_SEQ_RECALL))
          idx <= 6;
        else
          idx <= (pins.addr == `NVSP_SEQ_A0) ? 1 : 0;
      end else if (!pins.ce_n) rd_len <= rd_len + 1;
      if (!ce_q && pins.ce_n && idx > 0) begin
        if (rd_len * `NVSP_CLK_NS < `NVSP_TRC_NS) n_viol <= n_viol + 1;
        if (idx == 6) begin
          idx <= 0;
          latch <= 1'b0;
          if (cmd) begin
            n_store <= n_store + 1;
            nv <= mem;
            busy <= TSS_CYC + TSTORE_CYC;
          end else begin
            n_recall <= n_recall + 1;
            mem <= nv;
            busy <= TSS_CYC + TRECALL_CYC;
          end
        end
      end
      if (pins.hw_save_line_n_oe && latch) begin
        hs <= TSTORE_CYC;
        latch <= 1'b0;
        n_store <= n_store + 1;
        nv <= mem;
      end else if (hs > 0 && !pins.hw_save_line_n_oe) hs <= hs - 1;
    end
  end
endmodule

// >>> verif/nvsp_host_bench.sv
// self-checking bench of the host port against the device model
// assumes shortened boot, processing, store and restore counts
`timescale 1ns/1ps

module nvsp_host_bench import nvsp_pkg::*;;
  typedef struct {logic [15:0] d; logic [15:0] m;} nvsp_note_t;
  logic clk = 0;
  logic resetn = 0;
  nvsp_req_t req = '0;
  nvsp_rsp_t rsp;
  nvsp_pin_t pins;
  logic [15:0] dq, img [0:255];
  logic save_n;
  int n_store, n_recall, n_viol, n_fail = 0, cmp_count = 0, cyc = 0;
  int seed = 32'h6EA4;
  nvsp_note_t q[$];

  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  nvsp_host #(.TBOOT_CYC(20), .TSS_CYC(10), .TRECALL_CYC(10),
    .TSTORE_CYC(20)) nvsp_host_inst (.clk(clk), .resetn(resetn),
    .req(req), .rsp(rsp), .pins(pins), .dq_i(dq), .hw_save_line_n_i(save_n));
  // model defaults already match the shortened host counts
  nvsp_dev_model nvsp_dev_model_inst (.clk(clk), .resetn(resetn),
    .pins(pins), .dq(dq), .save_line_n(save_n), .n_store(n_store),
    .n_recall(n_recall), .n_viol(n_viol));

  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic op(input nvsp_op_t o, input logic [16:0] a,
    input logic [15:0] d, input logic [1:0] be);
    logic [15:0] m;
    int k;
    k = 0;
    m = (o == NVSP_OP_READ) ? {{8{be[1]}}, {8{be[0]}}} : 16'h0;
    @(negedge clk);
    while (rsp.ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 5000) n_fail++;
    q.push_back('{d & m, m});
    req <= '{1'b1, o, a, d, be};
    @(negedge clk);
    req.valid <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic [1:0] be);
    if (be[0]) img[a][7:0] = d[7:0];
    if (be[1]) img[a][15:8] = d[15:8];
    op(NVSP_OP_WRITE, {9'h0, a}, d, be);
  endtask

  task automatic hw(input logic slow);
    int t0, k;
    op(NVSP_OP_HWSAVE, 17'h0, 16'h0, 2'h0);
    t0 = cyc;
    k = 0;
    while (rsp.done !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 2000) n_fail++;
    check("hw_slow", {15'h0, cyc - t0 > 18}, {15'h0, slow});
  endtask

  // each done pops the oldest note; reads compare the enabled lanes
  always @(negedge clk) begin
    nvsp_note_t n;
    if (rsp.done === 1'b1) begin
      if (q.size() == 0) check("extra_done", 16'h1, 16'h0);
      else begin
        n = q.pop_front();
        check("rdata", rsp.rdata & n.m, n.d);
      end
    end
  end

  initial begin
    #100000;
    n_fail++;
    close_out();
  end

  initial begin
    logic [15:0] sv;
    repeat (5) @(negedge clk);
    resetn = 1;
    for (int i = 16; i < 32; i++) wr(8'(i), 16'($random(seed)), 2'h3);
    for (int i = 16; i < 32; i++)
      wr(8'(i), 16'($random(seed)), 2'($random(seed)));
    for (int i = 16; i < 32; i++)
      op(NVSP_OP_READ, 17'(i), img[i], 2'($random(seed)));
    sv = img[16];
    op(NVSP_OP_STORE, 17'h0, 16'h0, 2'h0);
    wr(8'h10, ~sv, 2'h3);
    op(NVSP_OP_RECALL, 17'h0, 16'h0, 2'h0);
    img[16] = sv;
    op(NVSP_OP_READ, 17'h10, sv, 2'h3);
    hw(1'b0);
    wr(8'h11, 16'h5AA5, 2'h3);
    hw(1'b1);
    op(nvsp_op_t'(3'h7), 17'h0, 16'h0, 2'h0);
    op(NVSP_OP_READ, 17'h11, 16'h5AA5, 2'h3);
    repeat (40) @(negedge clk);
    check("n_store", n_store[15:0], 16'h2);
    check("n_recall", n_recall[15:0], 16'h1);
    check("n_viol", n_viol[15:0], 16'h0);
    check("pending", 16'(q.size()), 16'h0);
    close_out();
  end
endmodule
